// ===== inc/mcu_decoder_params.svh
// constants for the instruction decoder: fields, opcodes, resets, addresses
`ifndef MCU_DECODER_PARAMS_SVH
`define MCU_DECODER_PARAMS_SVH
// ************************************************************
// word layout
// ************************************************************
`define INSTR_W    14
`define PC_W       11
`define F_GRP_HI   13
`define F_GRP_LO   12
`define F_OP_HI    11
`define F_OP_LO    8
`define F_DEST     7
`define F_FILE_HI  6
`define F_BIT_HI   9
`define F_BIT_LO   7
`define F_JMP_SEL  11
`define F_LIT_HI   7
// ************************************************************
// groups and opcodes
// ************************************************************
`define GRP_BYTE   2'h0
`define GRP_BIT    2'h1
`define GRP_CTRL   2'h2
`define GRP_LIT    2'h3
`define OPB_MISC   4'h0
`define OPB_CLR    4'h1
`define OPB_SUB    4'h2
`define OPB_DEC    4'h3
`define OPB_OR     4'h4
`define OPB_AND    4'h5
`define OPB_XOR    4'h6
`define OPB_ADD    4'h7
`define OPB_MOV    4'h8
`define OPB_COM    4'h9
`define OPB_INC    4'ha
`define OPB_DECSZ  4'hb
`define OPB_RRC    4'hc
`define OPB_RLC    4'hd
`define OPB_SWAP   4'he
`define OPB_INCSZ  4'hf
`define OPK_MOV    4'b00??
`define OPK_RET    4'b01??
`define OPK_OR     4'b1000
`define OPK_AND    4'b1001
`define OPK_XOR    4'b1010
`define OPK_SUB    4'b110?
`define OPK_ADD    4'b111?
`define WORD_RET   14'h0008
`define WORD_RETI  14'h0009
`define WORD_SLEEP 14'h0063
`define WORD_WDT   14'h0064
// ************************************************************
// reset values and special addresses
// ************************************************************
`define WREG_RST   8'h00
`define PC_RST     11'h000
`define TO_RST     1'b1
`define PD_RST     1'b1
`define TIMER_ADDR 7'h01
`define PORTA_ADDR 7'h05
`define PORTC_ADDR 7'h07
`endif

// ===== inc/mcu_decoder_pkg.sv
// types shared by the decoder and its arithmetic unit
package mcu_decoder_pkg;
   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CLR, OP_COM, OP_DEC,
      OP_INC, OP_MOV, OP_PASS_W, OP_RLC, OP_RRC, OP_SWAP, OP_BCLR, OP_BSET
   } alu_op_t;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage : mcu_decoder_pkg

// ===== logic/mcu_alu.sv
// eight-bit arithmetic and logic unit of the core
`timescale 1ns/10ps
module mcu_alu
   import mcu_decoder_pkg::*;
(
   // operation
   input  wire alu_op_t    op,
   input  wire logic [7:0] opnd,
   input  wire logic [7:0] wreg,
   input  wire logic       cin,
   input  wire logic [2:0] bsel,
   // result
   output logic      [7:0] res,
   output logic            cout,
   output logic            dcout
);
   logic [8:0] sum;
   logic [4:0] lo;
   always_comb begin
      sum   = 9'h000;
      lo    = 5'h00;
      res   = opnd;
      cout  = cin;
      dcout = 1'b0;
      case (op)
         OP_ADD: begin
            sum   = {1'b0, opnd} + {1'b0, wreg};
            lo    = {1'b0, opnd[3:0]} + {1'b0, wreg[3:0]};
            res   = sum[7:0];
            cout  = sum[8];
            dcout = lo[4];
         end
         OP_SUB: begin
            // carry set means no borrow
            sum   = {1'b0, opnd} + {1'b0, ~wreg} + 9'h001;
            lo    = {1'b0, opnd[3:0]} + {1'b0, ~wreg[3:0]} + 5'h01;
            res   = sum[7:0];
            cout  = sum[8];
            dcout = lo[4];
         end
         OP_AND:    res = opnd & wreg;
         OP_OR:     res = opnd | wreg;
         OP_XOR:    res = opnd ^ wreg;
         OP_CLR:    res = 8'h00;
         OP_COM:    res = ~opnd;
         OP_DEC:    res = opnd - 8'h01;
         OP_INC:    res = opnd + 8'h01;
         OP_PASS_W: res = wreg;
         OP_RLC: begin
            res  = {opnd[6:0], cin};
            cout = opnd[7];
         end
         OP_RRC: begin
            res  = {cin, opnd[7:1]};
            cout = opnd[0];
         end
         OP_SWAP:   res = {opnd[3:0], opnd[7:4]};
         OP_BCLR:   res = opnd & ~(8'h01 << bsel);
         OP_BSET:   res = opnd | (8'h01 << bsel);
         default:   res = opnd;
      endcase
   end
endmodule : mcu_alu

// ===== logic/mcu_instruction_decoder.sv
// decoder and executor for 14-bit instruction words
`timescale 1ns/10ps
`include "mcu_decoder_params.svh"
// Functional notes
// - every instruction is one 14-bit word
// - destination bit picks working or file register
// - four clocks per cycle, one cycle normally
// - file register is always read first
// - add file and working, flags C DC Z
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - decrement, skip on zero, flags kept
// - increment, skip on zero, flags kept
// - skip when selected bit is clear
// - skip when selected bit is set
// - clear chosen bit, flags kept
// - or and xor with file, zero only
// - or literal into working, zero flag
// - xor literal into working, zero flag
// - add literal to working, C DC Z
// - literal minus working, C DC Z
// - literal return loads working, two cycles
// - fixed return words, two cycles each
// - standby word sets timeout, clears powerdown
// - watchdog clear word sets both flags
// - port reads use pin levels
// - timer write clears assigned prescaler
// - redirect or skip adds a nop cycle
module mcu_instruction_decoder
   import mcu_decoder_pkg::*;
#(
   parameter int PC_WIDTH = `PC_W
)(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset,
   // program memory
   output logic [PC_WIDTH-1:0]      prog_addr_r,
   input  wire logic [`INSTR_W-1:0] prog_data,
   // file register bus
   output logic [6:0]               file_addr_r,
   output logic                     file_rd_r,
   output logic                     file_wr_r,
   output logic [7:0]               file_wdata_r,
   input  wire logic [7:0]          file_rdata,
   input  wire logic [7:0]          pin_rdata,
   // return stack
   output logic                     stack_push_r,
   output logic                     stack_pop_r,
   output logic [PC_WIDTH-1:0]      stack_wdata_r,
   input  wire logic [PC_WIDTH-1:0] stack_top,
   // timer, watchdog, standby
   input  wire logic                prescaler_on_timer,
   input  wire logic                wake,
   output logic                     prescaler_clr_r,
   output logic                     wdt_clr_r,
   output logic                     standby_r,
   output logic                     gie_set_r,
   // core state
   output logic [7:0]               wreg_r,
   output logic                     carry_r,
   output logic                     digit_carry_flag_r,
   output logic                     zero_r,
   output logic                     timeout_flag_r,
   output logic                     powerdown_flag_r
);
   if (PC_WIDTH < `PC_W) begin : g_chk
      $error("PC_WIDTH too small for 11-bit targets");
   end
   // ************************************************************
   // sequencing
   // ************************************************************
   phase_t              phase_r;
   logic [`INSTR_W-1:0] instr_r;
   logic                exec_r;
   logic                flush_r;
   logic [7:0]          operand_r;
   logic                commit;
   // standby holds the core at the start of a cycle until woken
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         phase_r <= PH_Q1;
      end else begin
         case (phase_r)
            PH_Q1:   if (!standby_r) phase_r <= PH_Q2;
            PH_Q2:   phase_r <= PH_Q3;
            PH_Q3:   phase_r <= PH_Q4;
            default: phase_r <= PH_Q1;
         endcase
      end
   end
   // the discarded word is fetched but never executed
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         instr_r <= 14'h0000;
         exec_r  <= 1'b0;
      end else if (phase_r == PH_Q1 && !standby_r) begin
         instr_r <= prog_data;
         exec_r  <= !flush_r;
      end
   end
   assign commit = (phase_r == PH_Q4) && exec_r;
   // ************************************************************
   // decode
   // ************************************************************
   logic [1:0] grp;
   logic [3:0] opc;
   logic       dest_f;
   logic [6:0] faddr;
   logic [4:0] op;
   logic       uses_f, use_lit, wr_w, wr_f;
   logic       upd_c, upd_dc, upd_z;
   logic       skip_zero, skip_clr, skip_set;
   logic       jump, call, ret, ret_lit, ret_int, sleep_op, wdt_op;
   assign grp    = instr_r[`F_GRP_HI:`F_GRP_LO];
   assign opc    = instr_r[`F_OP_HI:`F_OP_LO];
   assign dest_f = instr_r[`F_DEST];
   assign faddr  = instr_r[`F_FILE_HI:0];
   always_comb begin
      op = OP_MOV;
      {uses_f, use_lit, wr_w, wr_f} = 4'h0;
      {upd_c, upd_dc, upd_z} = 3'h0;
      {skip_zero, skip_clr, skip_set} = 3'h0;
      {jump, call, ret, ret_lit, ret_int, sleep_op, wdt_op} = 7'h00;
      case (grp)
         `GRP_BYTE: begin
            uses_f = 1'b1;
            wr_w   = !dest_f;
            wr_f   = dest_f;
            case (opc)
               `OPB_MISC: begin
                  op     = OP_PASS_W;
                  uses_f = dest_f;
                  wr_w   = 1'b0;
                  ret      = (instr_r == `WORD_RET);
                  ret_int  = (instr_r == `WORD_RETI);
                  sleep_op = (instr_r == `WORD_SLEEP);
                  wdt_op   = (instr_r == `WORD_WDT);
               end
               `OPB_CLR: begin
                  op    = OP_CLR;
                  upd_z = 1'b1;
               end
               `OPB_SUB: begin
                  op = OP_SUB;
                  {upd_c, upd_dc, upd_z} = 3'h7;
               end
               `OPB_ADD: begin
                  op = OP_ADD;
                  {upd_c, upd_dc, upd_z} = 3'h7;
               end
               `OPB_DEC:   {op, upd_z} = {OP_DEC, 1'b1};
               `OPB_OR:    {op, upd_z} = {OP_OR, 1'b1};
               `OPB_AND:   {op, upd_z} = {OP_AND, 1'b1};
               `OPB_XOR:   {op, upd_z} = {OP_XOR, 1'b1};
               `OPB_MOV:   {op, upd_z} = {OP_MOV, 1'b1};
               `OPB_COM:   {op, upd_z} = {OP_COM, 1'b1};
               `OPB_INC:   {op, upd_z} = {OP_INC, 1'b1};
               `OPB_DECSZ: {op, skip_zero} = {OP_DEC, 1'b1};
               `OPB_INCSZ: {op, skip_zero} = {OP_INC, 1'b1};
               `OPB_RRC:   {op, upd_c} = {OP_RRC, 1'b1};
               `OPB_RLC:   {op, upd_c} = {OP_RLC, 1'b1};
               default:    op = OP_SWAP;
            endcase
         end
         `GRP_BIT: begin
            uses_f = 1'b1;
            case (opc[3:2])
               2'h0:    {op, wr_f} = {OP_BCLR, 1'b1};
               2'h1:    {op, wr_f} = {OP_BSET, 1'b1};
               2'h2:    skip_clr = 1'b1;
               default: skip_set = 1'b1;
            endcase
         end
         `GRP_CTRL: begin
            jump = 1'b1;
            call = !instr_r[`F_JMP_SEL];
         end
         default: begin
            use_lit = 1'b1;
            wr_w    = 1'b1;
            casez (opc)
               `OPK_MOV: op = OP_MOV;
               `OPK_RET: {op, ret_lit} = {OP_MOV, 1'b1};
               `OPK_OR:  {op, upd_z} = {OP_OR, 1'b1};
               `OPK_AND: {op, upd_z} = {OP_AND, 1'b1};
               `OPK_XOR: {op, upd_z} = {OP_XOR, 1'b1};
               `OPK_SUB: begin
                  op = OP_SUB;
                  {upd_c, upd_dc, upd_z} = 3'h7;
               end
               `OPK_ADD: begin
                  op = OP_ADD;
                  {upd_c, upd_dc, upd_z} = 3'h7;
               end
               default: {op, wr_w} = {OP_MOV, 1'b0};
            endcase
         end
      endcase
   end
   // ************************************************************
   // operand fetch and arithmetic
   // ************************************************************
   logic [7:0] alu_in, alu_res;
   logic       alu_c, alu_dc, bit_val, skip_take, redirect, is_port;
   assign is_port = (faddr == `PORTA_ADDR) || (faddr == `PORTC_ADDR);
   // read one phase before use so the bus has one full clock to answer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         file_addr_r <= 7'h00;
         file_rd_r   <= 1'b0;
         operand_r   <= 8'h00;
      end else begin
         file_rd_r <= 1'b0;
         if (phase_r == PH_Q2) begin
            file_addr_r <= faddr;
            file_rd_r   <= exec_r && uses_f;
         end
         if (phase_r == PH_Q3) begin
            operand_r <= is_port ? pin_rdata : file_rdata;
         end
      end
   end
   assign alu_in = use_lit ? instr_r[`F_LIT_HI:0] : operand_r;
   mcu_alu u_alu (
      .op    (alu_op_t'(op)),
      .opnd  (alu_in),
      .wreg  (wreg_r),
      .cin   (carry_r),
      .bsel  (instr_r[`F_BIT_HI:`F_BIT_LO]),
      .res   (alu_res),
      .cout  (alu_c),
      .dcout (alu_dc)
   );
   assign bit_val   = operand_r[instr_r[`F_BIT_HI:`F_BIT_LO]];
   assign skip_take = (skip_zero && alu_res == 8'h00) ||
                      (skip_clr && !bit_val) ||
                      (skip_set && bit_val);
   assign redirect  = jump || ret || ret_lit || ret_int || skip_take;
   // ************************************************************
   // commit
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prog_addr_r <= PC_WIDTH'(`PC_RST);
         flush_r     <= 1'b0;
      end else if (commit) begin
         flush_r <= redirect;
         if (jump) begin
            prog_addr_r <= PC_WIDTH'(instr_r[10:0]);
         end else if (ret || ret_lit || ret_int) begin
            prog_addr_r <= stack_top;
         end else if (skip_take) begin
            prog_addr_r <= prog_addr_r + PC_WIDTH'(2);
         end else begin
            prog_addr_r <= prog_addr_r + PC_WIDTH'(1);
         end
      end else if (phase_r == PH_Q4) begin
         flush_r <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         file_wr_r    <= 1'b0;
         file_wdata_r <= 8'h00;
         wreg_r       <= `WREG_RST;
      end else begin
         file_wr_r <= commit && wr_f;
         if (commit && wr_f) file_wdata_r <= alu_res;
         if (commit && wr_w) wreg_r <= alu_res;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         carry_r            <= 1'b0;
         digit_carry_flag_r <= 1'b0;
         zero_r             <= 1'b0;
      end else if (commit) begin
         if (upd_c)  carry_r <= alu_c;
         if (upd_dc) digit_carry_flag_r <= alu_dc;
         if (upd_z)  zero_r <= (alu_res == 8'h00);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stack_push_r    <= 1'b0;
         stack_pop_r     <= 1'b0;
         stack_wdata_r   <= PC_WIDTH'(`PC_RST);
         prescaler_clr_r <= 1'b0;
         wdt_clr_r       <= 1'b0;
         gie_set_r       <= 1'b0;
      end else begin
         // call latches the address after itself as it jumps and pushes it one clock later
         stack_push_r  <= commit && call;
         stack_pop_r   <= commit && (ret || ret_lit || ret_int);
         if (commit && call) stack_wdata_r <= prog_addr_r + PC_WIDTH'(1);
         prescaler_clr_r <= commit && wr_f && faddr == `TIMER_ADDR &&
                            prescaler_on_timer;
         wdt_clr_r <= commit && wdt_op;
         gie_set_r <= commit && ret_int;
      end
   end
   // flags are active low: standby clears powerdown
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timeout_flag_r   <= `TO_RST;
         powerdown_flag_r <= `PD_RST;
         standby_r        <= 1'b0;
      end else if (commit && (sleep_op || wdt_op)) begin
         timeout_flag_r   <= 1'b1;
         powerdown_flag_r <= wdt_op;
         standby_r        <= sleep_op;
      end else if (wake) begin
         standby_r <= 1'b0;
      end
   end
   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_cycle_length: assert property (
      phase_r == PH_Q2 |=> phase_r == PH_Q3 ##1 phase_r == PH_Q4
         ##1 phase_r == PH_Q1) else $error("cycle not four clocks");
   chk_read_before: assert property (
      file_wr_r |-> $past(file_rd_r, 2)) else $error("write without read");
   chk_dest_working: assert property (
      commit && grp == `GRP_BYTE && !dest_f |=> !file_wr_r)
      else $error("d=0 wrote file");
   chk_add_result: assert property (
      commit && grp == `GRP_BYTE && opc == `OPB_ADD && !dest_f |=>
         wreg_r == 8'($past(wreg_r) + $past(operand_r)))
      else $error("add result wrong");
   chk_rotate_carry: assert property (
      commit && grp == `GRP_BYTE && opc == `OPB_RLC |=>
         carry_r == $past(operand_r[7]) && $stable(zero_r))
      else $error("rotate carry wrong");
   chk_skip_flags: assert property (
      commit && skip_zero |=> $stable(carry_r) && $stable(zero_r)
         && $stable(digit_carry_flag_r)) else $error("skip touched flags");
   chk_redirect_nop: assert property (
      commit && redirect |-> ##[1:2] (phase_r == PH_Q1)
         ##[1:8] !exec_r) else $error("no nop after redirect");
   chk_literal_ret: assert property (
      commit && ret_lit |=> wreg_r == $past(instr_r[7:0]) && stack_pop_r)
      else $error("literal return wrong");
   chk_prescaler_clr: assert property (
      commit && wr_f && faddr == `TIMER_ADDR && prescaler_on_timer
         |=> prescaler_clr_r) else $error("prescaler not cleared");
   chk_standby_flags: assert property (
      commit && sleep_op |=> standby_r && timeout_flag_r
         && !powerdown_flag_r) else $error("standby flags wrong");
   chk_wdt_flags: assert property (
      commit && wdt_op |=> wdt_clr_r && timeout_flag_r && powerdown_flag_r)
      else $error("watchdog clear flags wrong");
   cov_skip_taken: cover property (commit && skip_take);
   cov_call: cover property (commit && call ##[1:8] stack_push_r);
   cov_port_rmw: cover property (commit && wr_f && is_port);
   cov_standby: cover property (standby_r ##1 wake);
endmodule : mcu_instruction_decoder

// ===== tb/mcu_instruction_decoder_tb.sv
// self-checking bench for the instruction decoder with a reference model
`timescale 1ns/10ps
`include "mcu_decoder_params.svh"
module mcu_instruction_decoder_tb
   import mcu_decoder_pkg::*;
;
   logic        clk_sys, reset, file_rd_r, file_wr_r, stack_push_r;
   logic        stack_pop_r, prescaler_on_timer, wake, prescaler_clr_r;
   logic        wdt_clr_r, standby_r, gie_set_r, carry_r, zero_r;
   logic        digit_carry_flag_r, timeout_flag_r, powerdown_flag_r;
   logic [10:0] prog_addr_r, stack_wdata_r, stack_top;
   logic [13:0] prog_data;
   logic [6:0]  file_addr_r;
   logic [7:0]  file_wdata_r, file_rdata, pin_rdata, wreg_r;
   logic [13:0] rom [0:2047];
   logic [7:0]  mem [0:127];
   logic [7:0]  fm [0:127];
   logic [10:0] hw_stk [0:7];
   logic [10:0] m_stk [0:7];
   logic [2:0]  hw_sp, m_sp;
   logic [10:0] m_pc;
   logic [7:0]  m_w, r;
   logic        m_c, m_dc, m_z, m_to, m_pdown, redir, ex_wr, ret, jmp;
   integer      seed, errors, comparisons, n, kind;
   localparam logic [5:0] PRE [0:14] = '{6'h07, 6'h0d, 6'h0c, 6'h0b,
      6'h0f, 6'h04, 6'h06, 6'h10, 6'h18, 6'h1c, 6'h38, 6'h3a, 6'h3e,
      6'h3c, 6'h34};
   localparam logic [13:0] CORNER [0:19] = '{14'h3eff, 14'h3e01, 14'h0ba0,
      14'h0fa1, 14'h1c20, 14'h1820, 14'h0485, 14'h0681, 14'h3c00, 14'h2100,
      14'h345a, 14'h2155, 14'h0009, 14'h0d20, 14'h0ca1, 14'h13a1, 14'h0064,
      14'h3a0f, 14'h380f, 14'h0721};

   mcu_instruction_decoder mcu_instruction_decoder_i (.*);

   // ************************************************************
   // memories standing around the core
   // ************************************************************
   assign prog_data  = rom[prog_addr_r];
   assign file_rdata = mem[file_addr_r];
   assign stack_top  = hw_stk[hw_sp - 3'd1];

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (file_wr_r === 1'b1) mem[file_addr_r] <= file_wdata_r;
      if (stack_push_r === 1'b1) begin
         hw_stk[hw_sp] <= stack_wdata_r;
         hw_sp <= hw_sp + 3'd1;
      end
      if (stack_pop_r === 1'b1) hw_sp <= hw_sp - 3'd1;
   end

   // ************************************************************
   // reference model and checks
   // ************************************************************
   task automatic check(input string nm, input logic [19:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   // carry and digit carry are no-borrow flags when b is the complement
   task automatic add8(input logic [7:0] a, b, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = a + b + ci;
      h = a[3:0] + b[3:0] + ci;
      r = s[7:0];
      m_c = s[8];
      m_dc = h[4];
      m_z = (s[7:0] == 8'h00);
   endtask : add8

   task automatic run_model(input logic [13:0] iw);
      logic [7:0] fv, k;
      logic       sk;
      logic [1:0] dst;
      k = iw[7:0];
      sk = 1'b0;
      ret = 1'b0;
      jmp = 1'b0;
      dst = 2'h0;
      ex_wr = 1'b0;
      r = 8'h00;
      fv = fm[iw[6:0]];
      if (iw[6:0] == `PORTA_ADDR || iw[6:0] == `PORTC_ADDR) fv = pin_rdata;
      casez (iw)
         14'b00_0111_????????: begin add8(m_w, fv, 1'b0); dst = 2'h1; end
         14'b00_1101_????????: begin
            r = {fv[6:0], m_c}; m_c = fv[7]; dst = 2'h1; end
         14'b00_1100_????????: begin
            r = {m_c, fv[7:1]}; m_c = fv[0]; dst = 2'h1; end
         14'b00_1011_????????: begin
            r = fv - 8'h01; sk = (r == 8'h00); dst = 2'h1; end
         14'b00_1111_????????: begin
            r = fv + 8'h01; sk = (r == 8'h00); dst = 2'h1; end
         14'b00_0100_????????: begin r = m_w | fv; dst = 2'h1; end
         14'b00_0110_????????: begin r = m_w ^ fv; dst = 2'h1; end
         14'b01_00??_????????: begin
            r = fv & ~(8'h01 << iw[9:7]); dst = 2'h3; end
         14'b01_10??_????????: sk = ~fv[iw[9:7]];
         14'b01_11??_????????: sk = fv[iw[9:7]];
         14'b11_1000_????????: begin r = m_w | k; dst = 2'h2; end
         14'b11_1010_????????: begin r = m_w ^ k; dst = 2'h2; end
         14'b11_111?_????????: begin add8(m_w, k, 1'b0); dst = 2'h2; end
         14'b11_110?_????????: begin add8(k, ~m_w, 1'b1); dst = 2'h2; end
         14'b11_01??_????????: begin r = k; dst = 2'h2; ret = 1'b1; end
         `WORD_RET, `WORD_RETI: ret = 1'b1;
         `WORD_SLEEP: begin m_to = 1'b1; m_pdown = 1'b0; end
         `WORD_WDT: begin m_to = 1'b1; m_pdown = 1'b1; end
         14'b10_0???_????????: begin
            m_stk[m_sp] = m_pc + 11'h001; m_sp++; jmp = 1'b1; end
         14'b10_1???_????????: jmp = 1'b1;
         default: ;
      endcase
      if (iw[13:8] == 6'h04 || iw[13:8] == 6'h06 || iw[13:8] == 6'h38 ||
          iw[13:8] == 6'h3a) m_z = (r == 8'h00);
      if (dst == 2'h1) dst = iw[7] ? 2'h3 : 2'h2;
      if (dst == 2'h2) m_w = r;
      if (dst == 2'h3) begin
         ex_wr = 1'b1;
         fm[iw[6:0]] = r;
      end
      redir = sk | ret | jmp;
      if (ret) begin
         m_sp--;
         m_pc = m_stk[m_sp];
      end else if (jmp) m_pc = iw[10:0];
      else m_pc = m_pc + (sk ? 11'h002 : 11'h001);
   endtask : run_model

   // one instruction: fetch, read, commit, then the nop cycle if any
   task automatic step(input logic [13:0] iw);
      logic fop;
      fop = (iw[13] == 1'b0) && (iw[13:8] != 6'h00);
      rom[m_pc] = iw;
      // new pin and prescaler levels land on the fetch edge
      @(posedge clk_sys);
      pin_rdata <= 8'($random(seed));
      prescaler_on_timer <= 1'($random(seed));
      @(posedge clk_sys);
      #1;
      if (fop) check("file_rd", {file_rd_r, file_addr_r},
                     {1'b1, iw[6:0]});
      run_model(iw);
      repeat (2) @(posedge clk_sys);
      #1;
      check("wreg", wreg_r, m_w);
      check("flags",
            {carry_r, digit_carry_flag_r, zero_r}, {m_c, m_dc, m_z});
      check("pc",
            prog_addr_r, m_pc);
      check("file_wr", file_wr_r, ex_wr);
      if (ex_wr) check("file_data",
                       {file_addr_r, file_wdata_r}, {iw[6:0], r});
      check("presc_clr", prescaler_clr_r, ex_wr &&
            iw[6:0] == `TIMER_ADDR && prescaler_on_timer);
      check("standby",
            {timeout_flag_r, powerdown_flag_r, standby_r, wdt_clr_r},
            {m_to, m_pdown, iw == `WORD_SLEEP, iw == `WORD_WDT});
      check("stack",
            {stack_push_r, stack_pop_r, gie_set_r},
            {iw[13:11] == 3'b100, ret, iw == `WORD_RETI});
      if (iw[13:11] == 3'b100) check("ret_addr",
                                     stack_wdata_r, m_stk[m_sp - 3'd1]);
      if (redir) begin
         repeat (2) @(posedge clk_sys);
         #1;
         check("nop_rd", file_rd_r, 1'b0);
         repeat (2) @(posedge clk_sys);
         #1;
         check("nop_pc", {file_wr_r, prog_addr_r},
               {1'b0, m_pc});
      end
   endtask : step

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [31:0] v;
      logic [6:0]  f;
      seed = 63;
      errors = 0;
      comparisons = 0;
      reset = 1'b1;
      wake = 1'b0;
      pin_rdata = 8'h00;
      prescaler_on_timer = 1'b0;
      hw_sp = 3'h0;
      {m_sp, m_pc, m_w, m_c, m_dc, m_z, m_to, m_pdown} = {3'h0, 11'h000,
         8'h00, 3'h0, 2'h3};
      for (n = 0; n < 2048; n++) rom[n] = 14'h0000;
      for (n = 0; n < 128; n++) mem[n] = 8'($random(seed));
      mem[32] = 8'h01;
      mem[33] = 8'hff;
      for (n = 0; n < 128; n++) fm[n] = mem[n];
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      for (n = 0; n < 20; n++) step(CORNER[n]);
      for (n = 0; n < 300; n++) begin
         v = $random(seed);
         kind = {$random(seed)} % 20;
         if (kind >= 14 && kind <= 16 && m_sp == 3'h0) kind = 18;
         if (kind == 18 && m_sp == 3'h7) kind = 19;
         f = v[6:0];
         // keep clear of the special registers other than timer and ports
         if (f < 7'h20 && f != 7'h01 && f != 7'h05 && f != 7'h07) f[5] = 1'b1;
         if (kind < 7) step({PRE[kind], v[7], f});
         else if (kind < 10) step({PRE[kind][5:2], v[12:11], v[7], f});
         else if (kind < 15) step({PRE[kind], v[7:0]});
         else if (kind == 15) step(`WORD_RET);
         else if (kind == 16) step(`WORD_RETI);
         else if (kind == 17) step(`WORD_WDT);
         else step({2'b10, kind == 19, v[10:0]});
      end
      step(`WORD_SLEEP);
      @(posedge clk_sys);
      wake <= 1'b1;
      for (n = 0; n < 20 && standby_r !== 1'b0; n++) @(posedge clk_sys);
      #1;
      check("wake", standby_r, 1'b0);
      end_sim();
   end
endmodule : mcu_instruction_decoder_tb
